// ---- hw/comc_ctrl.sv ----
// Purpose: Camera output and memo command interpreter behind an APB slave
// Assumes: Serial encoder acknowledges each reply with a tx_done pulse
// Notes:   Commands are written to the command register, one at a time
`timescale 1ns/1ps
`include "comc_cfg.svh"

module comc_ctrl #(
    parameter int VIEW_N = 8
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        tx_done,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             video_format_select,
    output logic [9:0]       horiz_phase_trim,
    output logic [8:0]       vert_phase_trim,
    output logic             test_bar_pattern_sel,
    output logic [1:0]       mirror_mode,
    output logic [1:0]       serial_line_rate_sel,
    output logic [1:0]       display_sel,
    output logic             overlay_text_show,
    output logic             wb_onepush_start,
    output logic             memo_capture,
    output logic             memo_slot,
    output logic             reply_valid,
    output logic [1:0]       reply_kind,
    output logic [15:0]      reply_data
);

    typedef enum logic [5:0] {
        S_IDLE  = 6'b000001,
        S_EXEC  = 6'b000010,
        S_LOAD  = 6'b000100,
        S_REPLY = 6'b001000,
        S_VIEW  = 6'b010000,
        S_APPLY = 6'b100000
    } comc_state_t;

    if (VIEW_N < 1 || VIEW_N > 8) begin : g_chk
        $error("VIEW_N must be 1 to 8");
    end

    comc_state_t         state_r;
    comc_pkg::comc_set_t set_r;
    comc_pkg::comc_set_t nvm_rd;
    comc_pkg::comc_op_t  op_r;
    logic [9:0]          param_r;
    logic                pal_r;
    logic                ext_sync_r;
    logic [1:0]          memo_full_r;
    logic [1:0]          rate_pend_r;
    logic                pend_r;
    logic [2:0]          view_idx_r;
    logic                res_err_r;
    logic                apb_wr;
    logic                cmd_wr;
    logic                nvm_wr;
    logic                nvm_rd_en;

    // Parameter range check per command
    function automatic logic param_ok(comc_pkg::comc_op_t op, logic [9:0] p, logic pal);
        logic ok;
        ok = 1'b0;
        case (op)
            comc_pkg::OP_HPH:   ok = p <= (pal ? `COMC_HPH_MAX_625 : `COMC_HPH_MAX_525);
            comc_pkg::OP_VPH:   ok = p <= (pal ? `COMC_VPH_MAX_625 : `COMC_VPH_MAX_525);
            comc_pkg::OP_FLIP,
            comc_pkg::OP_MDISP: ok = p <= 10'h003;
            comc_pkg::OP_RATE,
            comc_pkg::OP_LOAD:  ok = p <= 10'h002;
            comc_pkg::OP_VFMT,
            comc_pkg::OP_BAR,
            comc_pkg::OP_OVL,
            comc_pkg::OP_MCAP,
            comc_pkg::OP_SAVE:  ok = p <= 10'h001;
            comc_pkg::OP_WB1,
            comc_pkg::OP_INIT,
            comc_pkg::OP_VIEW:  ok = 1'b1;
            default:            ok = 1'b0;
        endcase
        return ok;
    endfunction

    // One report word: field index and value
    function automatic logic [15:0] view_word(comc_pkg::comc_set_t s, logic [2:0] i);
        logic [11:0] v;
        v = 12'h000;
        case (i)
            3'h0:    v = {11'h000, s.video_format_select};
            3'h1:    v = {2'h0, s.horiz_phase_trim};
            3'h2:    v = {3'h0, s.vert_phase_trim};
            3'h3:    v = {11'h000, s.test_bar_pattern_sel};
            3'h4:    v = {10'h000, s.mirror_mode};
            3'h5:    v = {10'h000, s.serial_line_rate_sel};
            3'h6:    v = {11'h000, s.overlay_text_enable};
            default: v = {10'h000, s.display_sel};
        endcase
        return {1'b0, i, v};
    endfunction

    assign apb_wr  = psel && penable && pready && pwrite;
    assign cmd_wr  = apb_wr && (paddr == `COMC_CMD_OFS) && (state_r == S_IDLE);
    assign nvm_wr  = (state_r == S_EXEC) && (op_r == comc_pkg::OP_SAVE)
                     && param_ok(op_r, param_r, pal_r);
    assign nvm_rd_en = (state_r == S_EXEC) && (op_r == comc_pkg::OP_LOAD)
                       && param_ok(op_r, param_r, pal_r);

    comc_nvm #(
        .BANKS (3)
    ) u_nvm (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (nvm_wr),
        .wr_idx  ({1'b0, param_r[0]}),
        .wr_data (set_r),
        .rd_en   (nvm_rd_en),
        .rd_idx  (param_r[1:0]),
        .rd_data (nvm_rd)
    );

    // APB ready: raised by the setup cycle, so it stands in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (paddr[7:4] != 4'h0 || paddr[1:0] != 2'h0);
            if (psel && !penable) begin
                case (paddr)
                    `COMC_CMD_OFS:     prdata <= {12'h000, op_r, 6'h00, param_r};
                    `COMC_STATUS_OFS:  prdata <= {24'h0, memo_full_r, 4'h0,
                                                  res_err_r, state_r != S_IDLE};
                    `COMC_SETTING_OFS: prdata <= {4'h0, set_r};
                    `COMC_CONFIG_OFS:  prdata <= {30'h0, ext_sync_r, pal_r};
                    default:           prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Config bits: line standard and external sync lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pal_r      <= 1'b0;
            ext_sync_r <= 1'b0;
        end else if (apb_wr && paddr == `COMC_CONFIG_OFS) begin
            pal_r      <= pwdata[0];
            ext_sync_r <= pwdata[1];
        end
    end

    // Command capture, ignored while busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_r    <= comc_pkg::OP_NONE;
            param_r <= 10'h000;
        end else if (cmd_wr) begin
            op_r    <= comc_pkg::comc_op_t'(pwdata[`COMC_OP_MSB:`COMC_OP_LSB]);
            param_r <= pwdata[`COMC_PARAM_MSB:0];
        end
    end

    // Sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r    <= S_IDLE;
            view_idx_r <= 3'h0;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (cmd_wr) begin
                        state_r <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    view_idx_r <= 3'h0;
                    if (!res_err_next()) begin
                        if (op_r == comc_pkg::OP_LOAD) begin
                            state_r <= S_LOAD;
                        end else if (op_r == comc_pkg::OP_VIEW) begin
                            state_r <= S_VIEW;
                        end else begin
                            state_r <= S_REPLY;
                        end
                    end else begin
                        state_r <= S_REPLY;
                    end
                end
                S_LOAD:  state_r <= S_REPLY;
                S_VIEW: begin
                    if (tx_done) begin
                        if (view_idx_r == 3'(VIEW_N - 1)) begin
                            state_r <= S_REPLY;
                        end
                        view_idx_r <= view_idx_r + 3'h1;
                    end
                end
                S_REPLY: begin
                    if (tx_done) begin
                        state_r <= pend_r ? S_APPLY : S_IDLE;
                    end
                end
                S_APPLY: state_r <= S_IDLE;
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Error decision for the command under execution
    function automatic logic res_err_next();
        logic e;
        e = !param_ok(op_r, param_r, pal_r);
        if (op_r == comc_pkg::OP_MCAP && set_r.display_sel != `COMC_DISP_STILL) begin
            e = 1'b1;
        end
        if (op_r == comc_pkg::OP_MDISP) begin
            if (param_r[1:0] == `COMC_DISP_MEMO1 && !memo_full_r[0]) begin
                e = 1'b1;
            end
            if (param_r[1:0] == `COMC_DISP_MEMO2 && !memo_full_r[1]) begin
                e = 1'b1;
            end
            if (set_r.display_sel[1] && param_r[1:0] == `COMC_DISP_STILL) begin
                e = 1'b1;
            end
        end
        return e;
    endfunction

    // Settings store; applied before the OK reply, except a line rate set by OP_RATE, applied after the OK is sent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            set_r       <= comc_pkg::SET_DEFAULT;
            res_err_r   <= 1'b0;
            pend_r      <= 1'b0;
            rate_pend_r <= `COMC_RATE_DEF;
        end else if (state_r == S_EXEC) begin
            res_err_r <= res_err_next();
            pend_r    <= 1'b0;
            if (!res_err_next()) begin
                case (op_r)
                    comc_pkg::OP_VFMT:  set_r.video_format_select  <= param_r[0];
                    comc_pkg::OP_HPH:   set_r.horiz_phase_trim     <= param_r;
                    comc_pkg::OP_VPH:   set_r.vert_phase_trim      <= param_r[8:0];
                    comc_pkg::OP_BAR:   set_r.test_bar_pattern_sel <= param_r[0];
                    comc_pkg::OP_FLIP:  set_r.mirror_mode          <= param_r[1:0];
                    comc_pkg::OP_OVL:   set_r.overlay_text_enable  <= param_r[0];
                    comc_pkg::OP_MDISP: set_r.display_sel          <= param_r[1:0];
                    comc_pkg::OP_RATE: begin
                        rate_pend_r <= param_r[1:0];
                        pend_r      <= 1'b1;
                    end
                    comc_pkg::OP_INIT: begin
                        set_r <= comc_pkg::SET_DEFAULT;
                        set_r.serial_line_rate_sel <= set_r.serial_line_rate_sel;
                    end
                    default: ;
                endcase
            end
        end else if (state_r == S_LOAD) begin
            set_r <= nvm_rd;
        end else if (state_r == S_APPLY) begin
            set_r.serial_line_rate_sel <= rate_pend_r;
        end
    end

    // Memo fill flags are lost at reset, like volatile memory
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            memo_full_r <= 2'h0;
        end else if (memo_capture) begin
            memo_full_r[memo_slot] <= 1'b1;
        end
    end

    // Event pulses toward the video pipeline
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            memo_capture      <= 1'b0;
            memo_slot         <= 1'b0;
            wb_onepush_start  <= 1'b0;
            overlay_text_show <= 1'b0;
        end else begin
            memo_capture     <= (state_r == S_EXEC) && (op_r == comc_pkg::OP_MCAP)
                                && !res_err_next();
            wb_onepush_start <= (state_r == S_EXEC) && (op_r == comc_pkg::OP_WB1);
            if (state_r == S_EXEC) begin
                memo_slot <= param_r[0];
            end
            // Overlay only during one-push balance
            if (state_r == S_EXEC && op_r == comc_pkg::OP_WB1) begin
                overlay_text_show <= set_r.overlay_text_enable;
            end else if (state_r == S_IDLE || !set_r.overlay_text_enable) begin
                overlay_text_show <= 1'b0;
            end
        end
    end

    // Output image controls; trims only under external sync
    // Capture grabs the post-bar, post-frame stream, so bars freeze too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            video_format_select  <= `COMC_FMT_DEF;
            horiz_phase_trim     <= 10'h000;
            vert_phase_trim      <= 9'h000;
            test_bar_pattern_sel <= `COMC_BAR_DEF;
            mirror_mode          <= `COMC_FLIP_DEF;
            serial_line_rate_sel <= `COMC_RATE_DEF;
            display_sel          <= `COMC_DISP_DEF;
        end else begin
            video_format_select  <= set_r.video_format_select;
            horiz_phase_trim     <= ext_sync_r ? set_r.horiz_phase_trim : 10'h000;
            vert_phase_trim      <= ext_sync_r ? set_r.vert_phase_trim : 9'h000;
            test_bar_pattern_sel <= set_r.test_bar_pattern_sel;
            mirror_mode          <= set_r.mirror_mode;
            serial_line_rate_sel <= set_r.serial_line_rate_sel;
            display_sel          <= set_r.display_sel;
        end
    end

    // Serial reply: held until tx_done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reply_valid <= 1'b0;
            reply_kind  <= comc_pkg::RPL_OK;
            reply_data  <= 16'h0000;
        end else if (reply_valid && tx_done) begin
            reply_valid <= 1'b0;
        end else if (!reply_valid && state_r == S_VIEW) begin
            reply_valid <= 1'b1;
            reply_kind  <= comc_pkg::RPL_DATA;
            reply_data  <= view_word(set_r, view_idx_r);
        end else if (!reply_valid && state_r == S_REPLY) begin
            reply_valid <= 1'b1;
            reply_kind  <= res_err_r ? comc_pkg::RPL_ERR : comc_pkg::RPL_OK;
            reply_data  <= 16'h0000;
        end
    end

    a_rate_after_ok: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(set_r.serial_line_rate_sel) && $past(state_r) != S_EXEC
            && $past(state_r) != S_LOAD |-> $past(state_r, 2) == S_REPLY && $past(tx_done, 2))
        else $error("line rate changed before OK was sent");
    a_init_keeps_rate: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == S_EXEC && op_r == comc_pkg::OP_INIT |=> $stable(set_r.serial_line_rate_sel))
        else $error("initialise altered line rate");
    a_capture_still: assert property (@(posedge pclk) disable iff (!presetn)
        memo_capture |-> set_r.display_sel == `COMC_DISP_STILL)
        else $error("capture outside still mode");
    a_memo_shown_full: assert property (@(posedge pclk) disable iff (!presetn)
        set_r.display_sel == `COMC_DISP_MEMO2 |-> memo_full_r[1])
        else $error("empty memo 2 on display");
    a_bad_param_err: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == S_EXEC && !param_ok(op_r, param_r, pal_r) |=> res_err_r && $stable(set_r)
            ##[1:2] reply_valid && reply_kind == comc_pkg::RPL_ERR)
        else $error("bad parameter not refused");
    a_overlay_wb_only: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(overlay_text_show) |-> $past(op_r) == comc_pkg::OP_WB1 && set_r.overlay_text_enable)
        else $error("overlay text outside one-push balance");
    a_htrim_ext: assert property (@(posedge pclk) disable iff (!presetn)
        !ext_sync_r ##1 !ext_sync_r |-> horiz_phase_trim == 10'h000)
        else $error("horizontal trim applied without sync lock");
    a_ok_after_apply: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == S_EXEC && op_r == comc_pkg::OP_FLIP && !res_err_next()
            |=> set_r.mirror_mode == $past(param_r[1:0]) ##1 reply_valid)
        else $error("OK before mirror mode applied");

endmodule

// ---- hw/comc_cfg.svh ----
// Purpose: Offsets, defaults, ranges and codes of the camera output command controller
// Assumes: Included by the package and by the controller
// Notes:   Numbers only, no logic
`ifndef COMC_CFG_SVH
`define COMC_CFG_SVH

// Register byte offsets
`define COMC_CMD_OFS      8'h00
`define COMC_STATUS_OFS   8'h04
`define COMC_SETTING_OFS  8'h08
`define COMC_CONFIG_OFS   8'h0c

// Command word field positions
`define COMC_OP_LSB       16
`define COMC_OP_MSB       19
`define COMC_PARAM_MSB    9

// Factory defaults
`define COMC_FMT_DEF      1'h0
`define COMC_HPH_DEF      10'h068
`define COMC_VPH_DEF      9'h00a
`define COMC_BAR_DEF      1'h0
`define COMC_FLIP_DEF     2'h0
`define COMC_RATE_DEF     2'h2
`define COMC_OVL_DEF      1'h0
`define COMC_DISP_DEF     2'h0

// Parameter ceilings per line standard
`define COMC_HPH_MAX_525  10'h38e
`define COMC_HPH_MAX_625  10'h38c
`define COMC_VPH_MAX_525  10'h106
`define COMC_VPH_MAX_625  10'h138

// Selector values
`define COMC_DISP_LIVE    2'h0
`define COMC_DISP_STILL   2'h1
`define COMC_DISP_MEMO1   2'h2
`define COMC_DISP_MEMO2   2'h3
`define COMC_BANK_ALONE   2'h2

`endif

// ---- hw/comc_pkg.sv ----
// Purpose: Types shared by the camera output command controller files
// Assumes: comc_cfg.svh defines the defaults used here
// Notes:   Only types and one default constant
`include "comc_cfg.svh"

package comc_pkg;

    // Command codes
    typedef enum logic [3:0] {
        OP_NONE  = 4'h0,
        OP_VFMT  = 4'h1,
        OP_HPH   = 4'h2,
        OP_VPH   = 4'h3,
        OP_BAR   = 4'h4,
        OP_FLIP  = 4'h5,
        OP_RATE  = 4'h6,
        OP_OVL   = 4'h7,
        OP_WB1   = 4'h8,
        OP_MCAP  = 4'h9,
        OP_MDISP = 4'ha,
        OP_INIT  = 4'hb,
        OP_SAVE  = 4'hc,
        OP_LOAD  = 4'hd,
        OP_VIEW  = 4'he
    } comc_op_t;

    // Reply kinds on the serial side
    typedef enum logic [1:0] {
        RPL_OK   = 2'h0,
        RPL_ERR  = 2'h1,
        RPL_DATA = 2'h2
    } comc_rpl_t;

    // User camera control settings
    typedef struct packed {
        logic       video_format_select;
        logic [9:0] horiz_phase_trim;
        logic [8:0] vert_phase_trim;
        logic       test_bar_pattern_sel;
        logic [1:0] mirror_mode;
        logic [1:0] serial_line_rate_sel;
        logic       overlay_text_enable;
        logic [1:0] display_sel;
    } comc_set_t;

    localparam comc_set_t SET_DEFAULT = '{
        video_format_select:  `COMC_FMT_DEF,
        horiz_phase_trim:     `COMC_HPH_DEF,
        vert_phase_trim:      `COMC_VPH_DEF,
        test_bar_pattern_sel: `COMC_BAR_DEF,
        mirror_mode:          `COMC_FLIP_DEF,
        serial_line_rate_sel: `COMC_RATE_DEF,
        overlay_text_enable:  `COMC_OVL_DEF,
        display_sel:          `COMC_DISP_DEF
    };

endpackage

// ---- hw/comc_nvm.sv ----
// Purpose: Nonvolatile settings banks A, B and stand-alone
// Assumes: One write or one read per cycle
// Notes:   Read data appears one cycle after rd_en
`timescale 1ns/1ps

module comc_nvm #(
    parameter int BANKS = 3
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                wr_en,
    input  wire logic [1:0]          wr_idx,
    input  wire comc_pkg::comc_set_t wr_data,
    input  wire logic                rd_en,
    input  wire logic [1:0]          rd_idx,
    output comc_pkg::comc_set_t      rd_data
);

    comc_pkg::comc_set_t bank_r [BANKS];

    if (BANKS < 3 || BANKS > 4) begin : g_chk
        $error("comc_nvm needs three or four banks");
    end

    // Bank storage, preset to factory values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < BANKS; i++) begin
                bank_r[i] <= comc_pkg::SET_DEFAULT;
            end
        end else if (wr_en && (int'(wr_idx) < BANKS)) begin
            bank_r[wr_idx] <= wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= comc_pkg::SET_DEFAULT;
        end else if (rd_en && (int'(rd_idx) < BANKS)) begin
            rd_data <= bank_r[rd_idx];
        end
    end

endmodule

// ---- tb/comc_serial_host.sv ----
// Purpose: Serial host side model that finishes each reply of the controller
// Assumes: Controller holds reply_valid until it sees tx_done
// Notes:   slow and the current line rate stretch the shift time of a reply
`timescale 1ns/1ps

module comc_serial_host (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       reply_valid,
    input  wire logic       slow,
    input  wire logic [1:0] rate,
    output logic            tx_done
);
    int cnt;

    // Count shift time of one reply at the rate in force, then pulse tx_done once
    // A reply in flight keeps its rate, since the rate only moves between replies
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt     <= 0;
            tx_done <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            if (!reply_valid || tx_done) begin
                cnt <= 0;
            end else if (cnt == ((slow ? 12 : 2) << (2 - int'(rate)))) begin
                tx_done <= 1'b1;
                cnt     <= 0;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule

// ---- tb/test_camera_output_memo_cmd_ctrl.sv ----
// Purpose: Self-checking bench for the command controller
// Assumes: APB and reply timing as handed over by the designer
// Notes:   Integer settings model compared after every command
`timescale 1ns/1ps

module test_camera_output_memo_cmd_ctrl;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, e;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q, s = 32'h78a9c3bb;
    logic        pready, pslverr, tx_done, reply_valid;
    logic [9:0]  hph_o;
    logic [8:0]  vph_o;
    logic [1:0]  rate_o, kind_o, flip_o, disp_o;
    logic [15:0] rd_o;
    logic        fmt_o, bar_o, ovl_o, wb_o, cap_o, slot_o, ovl_q = 0;
    int          cap_n = 0, wb_n = 0, ovl_n = 0, exp_cap = 0, exp_wb = 0, exp_ovl = 0;
    int          fail_count = 0, n_checks = 0, p, k, bk[3][8];
    int          st[8] = '{0, 104, 10, 0, 0, 2, 0, 0};
    int          lim[16] = '{-1, 1, 910, 262, 1, 3, 2, 1, 0, 1, 3, 0, 1, 2, 0, -1};
    int          ops[28] = '{1, 2, 2, 3, 3, 4, 5, 6, 7, 8, 10, 9, 10, 9, 10, 10, 10, 10, 12, 11,
                             6, 13, 15, 2, 3, 2, 14, 13};
    int          prm[28] = '{1, 910, 911, 262, 263, 1, -1, 0, 1, 0, 2, 0, 1, 1, 3, 1, 2, 0, 1, 0,
                             3, 1, 0, 909, 312, -1, 0, 2};
    bit [1:0]    filled = 2'b00;
    bit          ok;

    comc_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .tx_done(tx_done), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .video_format_select(fmt_o),
        .horiz_phase_trim(hph_o), .vert_phase_trim(vph_o), .test_bar_pattern_sel(bar_o),
        .mirror_mode(flip_o), .serial_line_rate_sel(rate_o), .display_sel(disp_o),
        .overlay_text_show(ovl_o), .wb_onepush_start(wb_o), .memo_capture(cap_o),
        .memo_slot(slot_o), .reply_valid(reply_valid), .reply_kind(kind_o), .reply_data(rd_o));
    comc_serial_host HOST (.pclk(pclk), .presetn(presetn), .reply_valid(reply_valid),
        .slow(slow), .rate(rate_o), .tx_done(tx_done));

    // Count pulses and overlay rises seen by the video side
    always @(negedge pclk) begin
        cap_n += cap_o ? (slot_o ? 16 : 1) : 0;
        wb_n  += wb_o;
        ovl_n += ovl_o && !ovl_q;
        ovl_q = ovl_o;
    end

    // Clock, 25 ns period
    always #12.5 pclk = ~pclk;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic bound(inout int c);
        c++;
        if (c > 300) begin
            fail_count++;
            report_and_stop();
        end
    endtask

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask

    // Random source: 32-bit shift register, taps 32, 22, 2, 1
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Video pins packed like the settings word, overlay bit left clear
    function automatic logic [31:0] pins();
        return {4'h0, fmt_o, hph_o, vph_o, bar_o, flip_o, rate_o, 1'b0, disp_o};
    endfunction

    // Wait, bounded, until reply_valid shows level lv
    task automatic wait_rv(input logic lv);
        int c;
        c = 0;
        while (reply_valid !== lv) begin
            @(negedge pclk);
            bound(c);
        end
    endtask

    // One APB transfer, held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int c;
        c = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            bound(c);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Expected reply and settings after one command
    function automatic bit model(input int op, input int v);
        bit r;
        r = v <= lim[op];
        if (op == 9 && st[7] != 1) r = 0;
        if (op == 10 && v > 1 && !filled[v[0]]) r = 0;
        if (op == 10 && v == 1 && st[7] > 1) r = 0;
        if (r && op >= 1 && op <= 7) st[op-1] = v;
        if (r && op == 10) st[7] = v;
        if (r && op == 9) filled[v[0]] = 1'b1;
        if (r && op == 9) exp_cap += v[0] ? 16 : 1;
        if (r && op == 8) exp_wb++;
        if (r && op == 8) exp_ovl += st[6];
        if (r && op == 12) bk[v] = st;
        if (r && op == 13) st = bk[v];
        if (op == 11) st = '{0, 104, 10, 0, 0, st[5], 0, 0};
        return r;
    endfunction

    function automatic logic [31:0] exp_set();
        return {4'h0, st[0][0], st[1][9:0], st[2][8:0], st[3][0], st[4][1:0], st[5][1:0],
                st[6][0], st[7][1:0]};
    endfunction

    // Reset, defaults, unmapped access, then the command table
    initial begin
        foreach (bk[i]) bk[i] = st;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h08, 32'h0);
        chk("reset_settings", exp_set(), q);
        apb(0, 8'h10, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, e});
        apb(1, 8'h0c, 32'h2);
        foreach (ops[i]) begin
            if (i == 23) begin
                apb(1, 8'h0c, 32'h3);
                lim[2] = 908;
                lim[3] = 312;
            end
            s = lfsr(s);
            p = (prm[i] < 0) ? int'(s % (lim[ops[i]] + 1)) : prm[i];
            slow <= s[0];
            ok = model(ops[i], p);
            apb(1, 8'h00, {12'h0, ops[i][3:0], 6'h0, p[9:0]});
            for (int j = 0; j < ((ops[i] == 14) ? 8 : 0); j++) begin
                wait_rv(1'b1);
                chk("view", {17'h0, 3'(j), st[j][11:0]}, {16'h0, rd_o});
                chk("view_kind", 32'h2, {30'h0, kind_o});
                wait_rv(1'b0);
            end
            wait_rv(1'b1);
            chk("reply_kind", ok ? 32'h0 : 32'h1, {30'h0, kind_o});
            k = 0;
            do begin
                apb(0, 8'h04, 32'h0);
                bound(k);
            end while (q[0] !== 1'b0);
            apb(0, 8'h08, 32'h0);
            chk("settings", exp_set(), q);
            chk("pins", exp_set() & 32'h0fff_fffb, pins());
            chk("hph_out", st[1], {22'h0, hph_o});
            chk("rate_out", st[5], {30'h0, rate_o});
            chk("captures", exp_cap, cap_n);
            chk("wb_pulses", exp_wb, wb_n);
            chk("overlay_rises", exp_ovl, ovl_n);
        end
        report_and_stop();
    end
endmodule
